// *** rtl/sfbc_loader.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfbc_loader
   import sfbc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       boot_mode_sel_2,
   input  wire logic       boot_mode_sel_1,
   input  wire logic       boot_mode_sel_0,
   input  wire logic [7:0] strap_opcode,
   input  wire logic       force_reconfig_n,
   input  wire logic       flash_access_loaded,
   input  wire logic       flash_programmed,
   input  wire logic       jtag_tck,
   input  wire logic       jtag_tms,
   input  wire logic       jtag_tdi,
   output logic            jtag_tdo,
   output logic            flash_cs_n,
   output logic            flash_di,
   input  wire logic       flash_do,
   output logic            config_clock_out,
   output logic            config_clock_oe,
   output logic            fabric_clock_out,
   output logic            fabric_clock_oe,
   output logic            done_o,
   output logic            done_oe,
   output logic            init_ready_n,
   output logic            init_ready_oe,
   output logic [7:0]      cfg_byte,
   output logic            cfg_valid,
   input  wire logic       cfg_ready,
   output logic            cfg_error
);
   import sfbc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Link-side state on the JTAG clock: samples flash data and passes it back
   typedef struct packed {
      logic tdo;
   } sfbc_jtag_t;
   sfbc_jtag_t j;
   sfbc_jtag_t next_j;
   always_comb begin
      next_j     = j;
      next_j.tdo = flash_do;
   end
   always_ff @(negedge jtag_tck or negedge reset_n) begin
      if (!reset_n) begin
         j <= '0;
      end else begin
         j <= next_j; // R12
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main state
   typedef struct packed {
      sfbc_state_t st;
      logic [2:0]  mode;
      logic [7:0]  opcode;
      logic [1:0]  prog_n_sync;
      logic [1:0]  acc_sync;
      logic [1:0]  prog_sync;
      logic        prog_d;
      logic [1:0]  tck_sync;
      logic [1:0]  tms_sync;
      logic [1:0]  tdi_sync;
      logic [1:0]  fdo_sync;
      logic [1:0]  m2_sync;
      logic [1:0]  m1_sync;
      logic [1:0]  m0_sync;
      logic [7:0]  op_s1;
      logic [7:0]  op_s2;
      logic        strap_taken;
      logic [1:0]  settle;
      logic [3:0]  div;
      logic        sck;
      logic [31:0] hdr;
      logic [5:0]  hbit;
      logic [7:0]  rx;
      logic [2:0]  rbit;
      logic [23:0] left;
      logic [7:0]  wbyte;
      logic        wvalid;
      logic [7:0]  obyte;
      logic        ovalid;
      logic        cs_n;
      logic        di;
      logic        ck_out;
      logic        ck_oe;
      logic        fclk;
      logic        fclk_oe;
      logic        tdo;
      logic        done;
      logic        init_low;
      logic        err;
      logic        jtag_mode;
   } sfbc_main_t;
   sfbc_main_t s;
   sfbc_main_t next_s;

   logic       fifo_in_ready;
   logic [7:0] fifo_out_data;
   logic       fifo_out_valid;
   logic       fifo_out_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Buffer between the flash stream and the configuration sink
   sfbc_fifo #(
      .WIDTH (SFBC_FIFO_WIDTH),
      .DEPTH (SFBC_FIFO_DEPTH)
   ) sfbc_fifo_inst (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_data   (s.wbyte),
      .in_valid  (s.wvalid),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready)
   );

   logic [2:0] pins_mode;
   logic       rise;
   logic       fall;
   logic       flash_mode;
   logic       restart;
   assign pins_mode  = {s.m2_sync[1], s.m1_sync[1], s.m0_sync[1]};
   assign flash_mode = (s.mode == SFBC_MODE_STD) || (s.mode == SFBC_MODE_ALT);
   assign fifo_out_ready = !s.ovalid || cfg_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_s = s;
      next_s.prog_n_sync = {s.prog_n_sync[0], force_reconfig_n};
      next_s.acc_sync    = {s.acc_sync[0], flash_access_loaded};
      next_s.prog_sync   = {s.prog_sync[0], flash_programmed};
      next_s.prog_d      = s.prog_sync[1];
      next_s.tck_sync    = {s.tck_sync[0], jtag_tck};
      next_s.tms_sync    = {s.tms_sync[0], jtag_tms};
      next_s.tdi_sync    = {s.tdi_sync[0], jtag_tdi};
      next_s.fdo_sync    = {s.fdo_sync[0], j.tdo};
      next_s.m2_sync     = {s.m2_sync[0], boot_mode_sel_2};
      next_s.m1_sync     = {s.m1_sync[0], boot_mode_sel_1};
      next_s.m0_sync     = {s.m0_sync[0], boot_mode_sel_0};
      next_s.op_s1       = strap_opcode;
      next_s.op_s2       = s.op_s1;
      next_s.wvalid      = s.wvalid && !fifo_in_ready;
      rise    = 1'b0;
      fall    = 1'b0;
      restart = !s.prog_n_sync[1] || (s.prog_sync[1] && !s.prog_d); // R9 R17

      // Output register in front of the configuration sink
      if (fifo_out_ready) begin
         next_s.ovalid = fifo_out_valid; // R18
      end
      if (fifo_out_ready && fifo_out_valid) begin
         next_s.obyte = fifo_out_data;
      end

      // Serial clock divider, at most 50MHz toward the flash
      if (s.st == SFBC_HDR || (s.st == SFBC_DATA && !s.wvalid)) begin
         if (s.div == SFBC_HALF - 4'h1) begin // R15
            next_s.div = 4'h0;
            next_s.sck = !s.sck;
            rise = !s.sck;
            fall = s.sck;
         end else begin
            next_s.div = s.div + 4'h1;
         end
      end

      case (s.st)
         SFBC_IDLE: begin
            next_s.init_low = 1'b0; // R11
            next_s.done     = 1'b0;
            // Pin synchronisers fill before the mode is taken
            if (!s.strap_taken && s.settle != SFBC_SETTLE) begin
               next_s.settle = s.settle + 2'h1; // R2
            end else if (!s.strap_taken) begin
               next_s.strap_taken = 1'b1;
               next_s.mode = pins_mode; // R2
               next_s.opcode = (pins_mode == SFBC_MODE_ALT) ? s.op_s2 : SFBC_STD_OPCODE; // R1 R3
            end else if (flash_mode) begin
               next_s.cs_n    = 1'b0; // R18
               next_s.ck_oe   = 1'b1; // R13
               next_s.hdr     = {s.opcode, SFBC_START_ADDR};
               next_s.hbit    = 6'h0;
               next_s.di      = s.opcode[7]; // R5
               next_s.sck     = 1'b0;
               next_s.div     = 4'h0;
               next_s.left    = SFBC_LOAD_BYTES;
               next_s.rbit    = 3'h0;
               next_s.st      = SFBC_HDR;
            end else begin
               next_s.jtag_mode = 1'b1; // R2
            end
         end
         SFBC_HDR: begin
            if (fall) begin
               next_s.hbit = s.hbit + 6'h1;
               next_s.hdr  = {s.hdr[30:0], 1'b0};
               next_s.di   = s.hdr[30]; // R5 R18
               if (s.hbit == SFBC_HDR_BITS - 6'h1) begin
                  next_s.st = SFBC_DATA;
                  next_s.di = 1'b0;
               end
            end
         end
         SFBC_DATA: begin
            if (rise) begin
               next_s.rx   = {s.rx[6:0], flash_do}; // R6
               next_s.rbit = s.rbit + 3'h1;
               if (s.rbit == 3'h7) begin
                  next_s.wbyte  = {s.rx[6:0], flash_do};
                  next_s.wvalid = 1'b1;
                  next_s.left   = s.left - 24'h1;
                  if (s.left == 24'h1) begin
                     next_s.st = SFBC_DRAIN;
                  end
               end
            end
         end
         SFBC_DRAIN: begin
            if (s.sck == 1'b0) begin
               next_s.cs_n = 1'b1; // R18 R4
            end
            if (!s.wvalid && !fifo_out_valid && !s.ovalid) begin
               next_s.cs_n    = 1'b1;
               next_s.ck_oe   = 1'b0; // R13
               next_s.done    = 1'b1; // R10
               next_s.st      = SFBC_DONE;
            end
         end
         SFBC_DONE: begin
            next_s.done = 1'b1;
         end
         SFBC_ERROR: begin
            next_s.init_low = 1'b1; // R11
            next_s.done     = 1'b0; // R10
         end
         default: begin
            next_s.st    = SFBC_ERROR;
            next_s.err   = 1'b1;
            next_s.done  = 1'b0;
            next_s.cs_n  = 1'b1;
            next_s.ck_oe = 1'b0;
         end
      endcase
      next_s.ck_out = s.ck_oe ? s.sck : 1'b0;

      // After load, fabric owns the flash clock; JTAG may reach the flash
      if (s.st == SFBC_DONE || s.jtag_mode) begin
         if (s.acc_sync[1]) begin
            next_s.cs_n    = s.tms_sync[1]; // R16
            next_s.fclk    = s.tck_sync[1]; // R14
            next_s.fclk_oe = 1'b1;
            next_s.di      = s.tdi_sync[1];
            next_s.tdo     = s.fdo_sync[1];
         end else begin
            next_s.cs_n    = 1'b1;
            next_s.fclk_oe = 1'b0;
         end
      end

      if (restart) begin
         next_s.st          = SFBC_IDLE;
         next_s.strap_taken = 1'b0;
         next_s.cs_n        = 1'b1;
         next_s.ck_oe       = 1'b0;
         next_s.settle      = 2'h0;
         next_s.fclk_oe     = 1'b0;
         next_s.done        = 1'b0; // R10
         next_s.init_low    = 1'b1;
         next_s.err         = 1'b0;
         next_s.jtag_mode   = 1'b0;
         next_s.wvalid      = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s          <= '0;
         s.cs_n     <= 1'b1;
         s.init_low <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs from flip-flops, done_o and init_ready_n tied low, done_oe inverted and init_ready_oe an OR of two; four flash wires only
   assign flash_cs_n       = s.cs_n; // R8
   assign flash_di         = s.di;
   assign config_clock_out = s.ck_out;
   assign config_clock_oe  = s.ck_oe;
   assign fabric_clock_out = s.fclk;
   assign fabric_clock_oe  = s.fclk_oe;
   assign jtag_tdo         = s.tdo;
   assign done_o           = 1'b0;
   assign done_oe          = !s.done; // R10
   assign init_ready_n     = 1'b0;
   assign init_ready_oe    = s.init_low || s.err; // R11
   assign cfg_byte         = s.obyte;
   assign cfg_valid        = s.ovalid;
   assign cfg_error        = s.err;
endmodule
`default_nettype wire

// *** rtl/sfbc_pkg.sv ***
// Contract
// R1: Standard flash mode sends fixed read opcode 03H, no strapping needed.
// R2: Decode three mode pins at power-up; JTAG stays usable in every mode. In modes 000 and 001 the JTAG relay waits for load done.
// R3: Mode 001 takes the read opcode from eight strapped data pins.
// R4: Flash idles with output floating while chip select is high.
// R5: Opcode, address and data bits are valid at the flash rising clock edge.
// R6: Flash changes output after falling edge; device captures on next rising edge.
// R7: Flash pause input floats its output and ignores clock and data-in.
// R8: Flash port has only chip select, clock, data-in and data-out wires.
// R9: Driving force_reconfig_n low starts a new configuration sequence.
// R10: Open-drain done output released high only after successful configuration.
// R11: init_ready_n released high when ready, driven low when not ready or on error.
// R12: Cable operates the boundary-scan machine through TMS, TCK, TDI and TDO. No boundary-scan machine here; the four wires only relay to the flash.
// R13: Configuration clock output drives flash clock during load, tri-stated afterwards.
// R14: After load, fabric drives flash clock through a general-purpose pin.
// R15: Configuration clock toward the flash runs at no more than 50MHz.
// R16: With flash access loaded, the four JTAG wires connect to the four flash wires.
// R17: After JTAG programming of the flash, the device reconfigures from the flash.
// R18: Read lowers chip select, sends opcode, 24-bit address MSB first, streams bytes.
package sfbc_pkg;
   localparam logic [7:0]  SFBC_STD_OPCODE   = 8'h03;
   localparam logic [23:0] SFBC_START_ADDR   = 24'h000000;
   localparam logic [23:0] SFBC_LOAD_BYTES   = 24'h000100;
   localparam int          SFBC_CLK_MHZ      = 200;
   localparam int          SFBC_SCK_MAX_MHZ  = 50;
   localparam int          SFBC_HALF_CYC     = (SFBC_CLK_MHZ + 2 * SFBC_SCK_MAX_MHZ - 1) / (2 * SFBC_SCK_MAX_MHZ);
   localparam logic [3:0]  SFBC_HALF         = 4'(SFBC_HALF_CYC);
   localparam logic [5:0]  SFBC_HDR_BITS     = 6'h20;
   localparam logic [1:0]  SFBC_SETTLE       = 2'h3;
   localparam int          SFBC_FIFO_DEPTH   = 8;
   localparam int          SFBC_FIFO_WIDTH   = 8;
   localparam logic [2:0]  SFBC_MODE_STD     = 3'h0;
   localparam logic [2:0]  SFBC_MODE_ALT     = 3'h1;
   localparam logic [2:0]  SFBC_MODE_MSER    = 3'h4;
   localparam logic [2:0]  SFBC_MODE_SSER    = 3'h6;
   localparam logic [2:0]  SFBC_MODE_MPAR    = 3'h7;
   localparam logic [2:0]  SFBC_MODE_SPAR    = 3'h3;
   typedef enum logic [2:0] {
      SFBC_IDLE  = 3'b000,
      SFBC_HDR   = 3'b001,
      SFBC_DATA  = 3'b010,
      SFBC_DRAIN = 3'b011,
      SFBC_DONE  = 3'b100,
      SFBC_ERROR = 3'b101
   } sfbc_state_t;
endpackage

// *** rtl/sfbc_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfbc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } sfbc_fifo_t;
   sfbc_fifo_t s;
   sfbc_fifo_t next_s;
   logic push;
   logic pop;
   assign in_ready  = s.cnt != (AW+1)'(DEPTH);
   assign out_valid = s.cnt != '0;
   assign out_data  = s.mem[s.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_data;
         next_s.wr = s.wr + 1'b1;
      end
      if (pop) begin
         next_s.rd = s.rd + 1'b1;
      end
      next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// *** bench/sfbc_loader_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfbc_loader_asserts (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       force_reconfig_n,
   input wire logic       flash_access_loaded,
   input wire logic       flash_cs_n,
   input wire logic       flash_di,
   input wire logic       config_clock_out,
   input wire logic       config_clock_oe,
   input wire logic       done_o,
   input wire logic       done_oe,
   input wire logic       init_ready_oe,
   input wire logic [7:0] cfg_byte,
   input wire logic       cfg_valid,
   input wire logic       cfg_ready,
   input wire logic       cfg_error
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Read frame opens and stays selected for eight clk cycles
   sequence s_open;
      $fell(flash_cs_n);
   endsequence
   sequence s_held;
      !flash_cs_n [*8];
   endsequence
   //////////////////////////////////////////////////
   hdr_hold_a: assert property (s_open |-> s_held)
      else $error("select dropped inside header");
   sck_select_a: assert property ($rose(config_clock_out) && config_clock_oe |-> !flash_cs_n)
      else $error("clock edge while deselected");
   di_setup_a: assert property ($rose(config_clock_out) |-> $stable(flash_di))
      else $error("data moved at sampling edge");
   sck_rate_a: assert property ($changed(config_clock_out) |=> $stable(config_clock_out))
      else $error("flash clock too fast");
   clk_drive_a: assert property (!flash_cs_n && !flash_access_loaded |-> config_clock_oe)
      else $error("flash clock undriven during load");
   done_release_a: assert property ($fell(done_oe) |-> ##[0:1] (flash_cs_n && !config_clock_oe))
      else $error("done released during load");
   done_level_a: assert property (!done_oe |-> !done_o && !cfg_valid && !config_clock_oe)
      else $error("done released with load pending");
   restart_a: assert property ($fell(force_reconfig_n) |-> ##[1:16] (flash_cs_n && done_oe))
      else $error("restart not taken");
   stream_hold_a: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_byte))
      else $error("byte lost under back-pressure");
   error_init_a: assert property (cfg_error |-> init_ready_oe && done_oe)
      else $error("error without init low");
   init_release_a: assert property (!flash_cs_n |-> !init_ready_oe)
      else $error("flash selected while not ready");
endmodule
bind sfbc_loader sfbc_loader_asserts sfbc_loader_asserts_inst (.clk, .reset_n, .force_reconfig_n,
   .flash_access_loaded, .flash_cs_n, .flash_di, .config_clock_out, .config_clock_oe, .done_o, .done_oe,
   .init_ready_oe, .cfg_byte, .cfg_valid, .cfg_ready, .cfg_error);
`default_nettype wire

// *** bench/sfbc_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfbc_flash_model #(
   parameter int DLY = 1
) (
   input  wire logic  cs_n,
   input  wire logic  sck,
   input  wire logic  di,
   output logic       do_o,
   output logic [7:0] op,
   output logic [23:0] addr
);
   int          bitc;
   logic [31:0] hdr;
   logic [7:0]  cur;
   logic        hold_n;
   function automatic logic [7:0] mem(int n);
      return 8'(n * 7) ^ 8'hA5;
   endfunction
   initial do_o = 1'b0;
   // Pause pin strapped inactive: the device port has no pause wire
   assign hold_n = 1'b1;
   //////////////////////////////////////////////////
   // Selection restarts the instruction; release toggles the output
   always @(negedge cs_n) bitc = 0;
   always @(posedge cs_n) do_o <= ~do_o;
   // Instruction and address taken at the rising edge
   always @(posedge sck) begin
      if (!cs_n && hold_n) begin
         if (bitc < 32) hdr = {hdr[30:0], di};
         bitc++;
         if (bitc == 32) {op, addr} = hdr;
      end
   end
   // Data moves after the falling edge, a little late
   always @(negedge sck) begin
      if (!cs_n && hold_n && bitc >= 32) begin
         cur = mem((bitc - 32) / 8);
         do_o <= #DLY cur[7 - (bitc - 32) % 8];
      end
   end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sfbc_pkg::*;
   logic        clk, reset_n, boot_mode_sel_2, boot_mode_sel_1, boot_mode_sel_0, tck_en;
   logic        force_reconfig_n, flash_access_loaded, flash_programmed, cfg_ready;
   logic        jtag_tck, jtag_tms, jtag_tdi, jtag_tdo, flash_cs_n, flash_di, flash_do;
   logic        config_clock_out, config_clock_oe, fabric_clock_out, fabric_clock_oe;
   logic        done_o, done_oe, init_ready_n, init_ready_oe, cfg_valid, cfg_error;
   logic [7:0]  strap_opcode, cfg_byte, fop;
   logic [23:0] faddr;
   logic [2:0]  nf [4];
   int          num_errors, n_tests, seed, idx, cyc;
   wire logic   sck;
   // Pull-down holds the flash clock low when nobody drives it
   assign sck = config_clock_oe ? config_clock_out : fabric_clock_oe & fabric_clock_out;
   sfbc_loader sfbc_loader_inst (.clk, .reset_n, .boot_mode_sel_2, .boot_mode_sel_1, .boot_mode_sel_0,
      .strap_opcode, .force_reconfig_n, .flash_access_loaded, .flash_programmed, .jtag_tck, .jtag_tms,
      .jtag_tdi, .jtag_tdo, .flash_cs_n, .flash_di, .flash_do, .config_clock_out, .config_clock_oe,
      .fabric_clock_out, .fabric_clock_oe, .done_o, .done_oe, .init_ready_n, .init_ready_oe, .cfg_byte,
      .cfg_valid, .cfg_ready, .cfg_error);
   sfbc_flash_model #(.DLY(3)) sfbc_flash_model_inst (.cs_n(flash_cs_n), .sck(sck), .di(flash_di),
      .do_o(flash_do), .op(fop), .addr(faddr));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      jtag_tck = 1'b0;
      forever #3 jtag_tck = tck_en & ~jtag_tck;
   end
   //////////////////////////////////////////////////
   function automatic logic [7:0] exp_byte(int n);
      return 8'(n * 7) ^ 8'hA5;
   endfunction
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out;
      $display("Checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic restart(logic [2:0] m);
      {boot_mode_sel_2, boot_mode_sel_1, boot_mode_sel_0} = m;
      force_reconfig_n = 1'b0;
      repeat (4) @(negedge clk);
      force_reconfig_n = 1'b1;
   endtask
   // Streams one load with random and long stalls, then checks the frame
   task automatic load(logic [7:0] op);
      idx = 0;
      for (cyc = 0; cyc < 40000 && idx < int'(SFBC_LOAD_BYTES); cyc++) begin
         @(negedge clk);
         cfg_ready = (cyc % 3000 > 2500) ? 1'b0 : (($random(seed) & 3) != 0);
         if (cfg_valid === 1'b1 && cfg_ready) begin
            chk("cfg_byte", exp_byte(idx), cfg_byte);
            idx++;
         end
      end
      for (cyc = 0; cyc < 200 && done_oe !== 1'b0; cyc++) @(negedge clk);
      chk("byte count", SFBC_LOAD_BYTES, idx);
      chk("done_oe", 0, done_oe);
      chk("clock_oe", 0, config_clock_oe);
      chk("init_oe", 0, init_ready_oe);
      chk("opcode", op, fop);
      chk("address", SFBC_START_ADDR, faddr);
      $display("Load with opcode %h ended", op);
      if (idx != int'(SFBC_LOAD_BYTES) || done_oe !== 1'b0) close_out;
   endtask
   initial begin
      seed = 32'hD2C7;
      {reset_n, force_reconfig_n, flash_access_loaded, flash_programmed, tck_en} = 5'h08;
      {boot_mode_sel_2, boot_mode_sel_1, boot_mode_sel_0} = SFBC_MODE_STD;
      {jtag_tms, jtag_tdi, cfg_ready} = 3'h6;
      strap_opcode = 8'($random(seed)) | 8'h80;
      nf = '{SFBC_MODE_MSER, SFBC_MODE_SSER, SFBC_MODE_MPAR, SFBC_MODE_SPAR};
      repeat (16) @(negedge clk);
      chk("cs_n in reset", 1, flash_cs_n);
      chk("done_oe in reset", 1, done_oe);
      chk("init_oe in reset", 1, init_ready_oe);
      chk("init level", 0, init_ready_n);
      chk("done level", 0, done_o);
      reset_n = 1'b1;
      load(SFBC_STD_OPCODE);
      restart(SFBC_MODE_ALT);
      load(strap_opcode);
      foreach (nf[i]) begin
         restart(nf[i]);
         repeat (300) @(negedge clk);
         chk("cs_n other mode", 1, flash_cs_n);
         chk("clock_oe other mode", 0, config_clock_oe);
         $display("Mode %b left flash idle", nf[i]);
      end
      {boot_mode_sel_2, boot_mode_sel_1, boot_mode_sel_0} = SFBC_MODE_STD;
      flash_programmed = 1'b1;
      load(SFBC_STD_OPCODE);
      flash_programmed = 1'b0;
      flash_access_loaded = 1'b1;
      tck_en = 1'b1;
      jtag_tms = 1'b0;
      repeat (20) @(negedge clk);
      chk("relay cs_n", 0, flash_cs_n);
      chk("relay di", 1, flash_di);
      chk("relay tdo", flash_do, jtag_tdo);
      chk("fabric clock oe", 1, fabric_clock_oe);
      jtag_tms = 1'b1;
      tck_en = 1'b0;
      repeat (20) @(negedge clk);
      chk("relay cs_n off", 1, flash_cs_n);
      chk("fabric clock idle", 0, fabric_clock_out);
      chk("cfg_error", 0, cfg_error);
      $display("Relay test ended");
      close_out;
   end
endmodule
`default_nettype wire
